// ---- inc/decode_defs.svh ----
/*
  Constants of the instruction decode and timing block: opcode encodings,
  field positions, reset values and the program counter register address.
  Assumes it is included by bare name from the modules and the testbench.
*/
// Functional notes
// - Instruction words are 15 bits wide.
// - Default instruction takes one two-clock cycle.
// - Writing program counter register costs two cycles.
// - Branches, returns, true skips take two cycles.
// - Set, clear, test any register bit.
// - Port registers use the general register path.
// - Literal operand is 8 or 10 bits.
// - Sleep clears watchdog, stops oscillator, updates flags.
// - Return pops stack, flags unchanged.
// - Return from interrupt pops and enables interrupts.
// - Decrement into accumulator, skip on zero.
// - Decrement register in place, skip on zero.
// - Rotate right through carry into accumulator.
`ifndef DECODE_DEFS_SVH
`define DECODE_DEFS_SVH
`define IW_W 15
`define PC_W 12
`define STK_D 8
`define SP_W 3
`define OP_SLEEP 15'h0003
`define OP_ENI 15'h0010
`define OP_DISI 15'h0011
`define OP_RETURN 15'h0012
`define OP_RETURN_IRQ 15'h0013
`define OP_MOVRA 7'h01
`define OP_CLRR 7'h03
`define OP_DEC_ACC_SKIP 7'h16
`define OP_DEC_REG_SKIP 7'h17
`define OP_ROT_CARRY_ACC 7'h18
`define OP_INC_ACC_SKIP 7'h1e
`define OP_INC_REG_SKIP 7'h1f
`define OP_RETURN_LIT 7'h70
`define OP_BC 4'h4
`define OP_BS 4'h5
`define OP_SKIP_BIT_CLR 4'h6
`define OP_SKIP_BIT_SET 4'h7
`define OP_CALL 3'h4
`define OP_JUMP 3'h5
`define OP_LONG_CALL 11'h7a8
`define OP_LONG_JUMP 11'h7ac
`define PC_STEP2 12'h002
`define F7_HI 14
`define F7_LO 8
`define PC_REG_ADDR 8'h02
`define ACC_RST 8'h00
`define PC_RST 12'h000
`define SP_RST 3'h0
`define ONE8 8'h01
`define ONE12 12'h001
`define ONE3 3'h1
`endif

// ---- inc/decode_pkg.sv ----
/*
  Types shared by the decoder and its classifier.
  Assumes decode_defs.svh is on the include path.
*/
package decode_pkg;
  typedef enum logic [4:0] {
    OPC_NOP = 5'h00, OPC_SLEEP = 5'h01, OPC_ENI = 5'h02, OPC_DISI = 5'h03,
    OPC_RETURN = 5'h04, OPC_RETURN_IRQ = 5'h05, OPC_MOVRA = 5'h06, OPC_CLRR = 5'h07,
    OPC_DEC_ACC_SKIP = 5'h08, OPC_DEC_REG_SKIP = 5'h09, OPC_ROT_CARRY_ACC = 5'h0a,
    OPC_INC_ACC_SKIP = 5'h0b, OPC_INC_REG_SKIP = 5'h0c, OPC_BC = 5'h0d, OPC_BS = 5'h0e,
    OPC_SKIP_BIT_CLR = 5'h0f, OPC_SKIP_BIT_SET = 5'h10, OPC_CALL = 5'h11,
    OPC_JUMP = 5'h12, OPC_RETURN_LIT = 5'h13, OPC_LONG_CALL = 5'h14, OPC_LONG_JUMP = 5'h15
  } opclass_t;
  typedef enum logic [0:0] {ST_EXEC = 1'b0, ST_FLUSH = 1'b1} cyc_state_t;
endpackage

// ---- inc/decoded_if.sv ----
/*
  Decoded fields passed from the classifier to the execution logic.
  Assumes decode_pkg is compiled first.
*/
`timescale 1ns/100ps
interface decoded_if;
  import decode_pkg::*;
  opclass_t op;
  logic [7:0] reg_sel;
  logic [2:0] bit_sel;
  logic [7:0] lit8;
  logic [9:0] lit10;
  modport producer(output op, output reg_sel, output bit_sel, output lit8, output lit10);
  modport consumer(input op, input reg_sel, input bit_sel, input lit8, input lit10);
endinterface

// ---- rtl/opcode_classifier.sv ----
/*
  Combinational opcode classifier: maps a 15-bit word to an opcode class and
  splits out its operand fields. Assumes the word is stable while it is read.
*/
`timescale 1ns/100ps
`include "decode_defs.svh"
module opcode_classifier
  import decode_pkg::*;
(
  input wire logic [`IW_W-1:0] word,
  decoded_if.producer dec
);
  logic [6:0] f7;
  assign f7 = word[`F7_HI:`F7_LO];
  // Operand fields sit at fixed places, so they are split out unconditionally.
  assign dec.reg_sel = word[7:0];
  assign dec.bit_sel = word[10:8];
  assign dec.lit8 = word[7:0];
  assign dec.lit10 = word[9:0];

  always_comb begin
    dec.op = OPC_NOP;
    if (word == `OP_SLEEP) begin
      dec.op = OPC_SLEEP;
    end else if (word == `OP_ENI) begin
      dec.op = OPC_ENI;
    end else if (word == `OP_DISI) begin
      dec.op = OPC_DISI;
    end else if (word == `OP_RETURN) begin
      dec.op = OPC_RETURN;
    end else if (word == `OP_RETURN_IRQ) begin
      dec.op = OPC_RETURN_IRQ;
    end else if (f7 == `OP_MOVRA) begin
      dec.op = OPC_MOVRA;
    end else if (f7 == `OP_CLRR) begin
      dec.op = OPC_CLRR;
    end else if (f7 == `OP_DEC_ACC_SKIP) begin
      dec.op = OPC_DEC_ACC_SKIP;
    end else if (f7 == `OP_DEC_REG_SKIP) begin
      dec.op = OPC_DEC_REG_SKIP;
    end else if (f7 == `OP_ROT_CARRY_ACC) begin
      dec.op = OPC_ROT_CARRY_ACC;
    end else if (f7 == `OP_INC_ACC_SKIP) begin
      dec.op = OPC_INC_ACC_SKIP;
    end else if (f7 == `OP_INC_REG_SKIP) begin
      dec.op = OPC_INC_REG_SKIP;
    end else if (f7 == `OP_RETURN_LIT) begin
      dec.op = OPC_RETURN_LIT;
    end else if (word[14:4] == `OP_LONG_CALL) begin
      dec.op = OPC_LONG_CALL;
    end else if (word[14:4] == `OP_LONG_JUMP) begin
      dec.op = OPC_LONG_JUMP;
    end else if (word[14:11] == `OP_BC) begin
      dec.op = OPC_BC;
    end else if (word[14:11] == `OP_BS) begin
      dec.op = OPC_BS;
    end else if (word[14:11] == `OP_SKIP_BIT_CLR) begin
      dec.op = OPC_SKIP_BIT_CLR;
    end else if (word[14:11] == `OP_SKIP_BIT_SET) begin
      dec.op = OPC_SKIP_BIT_SET;
    end else if (word[14:12] == `OP_CALL) begin
      dec.op = OPC_CALL;
    end else if (word[14:12] == `OP_JUMP) begin
      dec.op = OPC_JUMP;
    end
  end
endmodule

// ---- rtl/instruction_decode_timing.sv ----
/*
  Instruction decode and cycle timing for an 8-bit core: fetch address out,
  15-bit word in, execution of the decoded operation and the 1/2 cycle pacing.
  Assumes program memory returns the word at fetch_addr within one clock and
  the register file answers reg_rdata for reg_addr within one clock.
*/
`timescale 1ns/100ps
`include "decode_defs.svh"
module instruction_decode_timing
  import decode_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [`IW_W-1:0] instr_word,
  input wire logic [7:0] reg_rdata,
  output logic [`PC_W-1:0] fetch_addr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_we,
  output logic [7:0] acc,
  output logic carry,
  output logic irq_enable,
  output logic wdt_clear,
  output logic osc_stop,
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic exec_phase
);
  decoded_if dec();
  opclass_t op;

  cyc_state_t state_q, state_d;
  logic phase_q, phase_d;
  logic [`PC_W-1:0] pc_q, pc_d;
  logic [7:0] acc_q, acc_d, addr_q, addr_d, wdata_q, wdata_d;
  logic carry_q, carry_d, we_q, we_d, ie_q, ie_d;
  logic wdtc_q, wdtc_d, stop_q, stop_d, to_q, to_d, pd_q, pd_d;
  logic [`SP_W-1:0] sp_q, sp_d;
  logic [`PC_W-1:0] stack_q [`STK_D];
  logic push;
  logic [`PC_W-1:0] top;
  logic [`PC_W-1:0] ret_addr;
  logic hold_q, hold_d;

  opcode_classifier u_class (
    .word(instr_word),
    .dec(dec)
  );
  assign op = dec.op;

  // The program counter register is held here, so its low byte is read locally.
  function automatic logic [7:0] operand(input logic [7:0] a, input logic [7:0] ext,
                                         input logic [`PC_W-1:0] pc);
    operand = (a == `PC_REG_ADDR) ? pc[7:0] : ext;
  endfunction

  function automatic logic [`PC_W-1:0] page_jump(input logic [`PC_W-1:0] pc,
                                                 input logic [9:0] k);
    page_jump = {pc[`PC_W-1:10], k};
  endfunction

  logic [7:0] src, dec_val, inc_val, bit_mask;
  logic [`PC_W-1:0] pc_next;
  logic bit_val;
  assign src = operand(addr_q, reg_rdata, pc_q);
  assign dec_val = src - `ONE8;
  assign inc_val = src + `ONE8;
  assign bit_mask = `ONE8 << dec.bit_sel;
  assign bit_val = src[dec.bit_sel];
  assign pc_next = pc_q + `ONE12;
  // A long call is two words long, so it must return past its target word.
  assign ret_addr = (op == OPC_LONG_CALL) ? pc_q + `PC_STEP2 : pc_next;
  assign top = stack_q[sp_q - `ONE3];

  // Writes into the register file; a write to the program counter register
  // is steered into the counter and costs a flush cycle.
  task automatic reg_write(input logic [7:0] v);
    if (addr_q == `PC_REG_ADDR) begin
      pc_d = {pc_q[`PC_W-1:8], v};
      state_d = ST_FLUSH;
      hold_d = 1'b1;
    end else begin
      wdata_d = v;
      we_d = 1'b1;
    end
  endtask

  always_comb begin
    phase_d = ~phase_q;
    state_d = state_q;
    pc_d = pc_q;
    acc_d = acc_q;
    carry_d = carry_q;
    addr_d = phase_q ? addr_q : dec.reg_sel;
    wdata_d = wdata_q;
    we_d = 1'b0;
    ie_d = ie_q;
    wdtc_d = 1'b0;
    stop_d = 1'b0;
    to_d = to_q;
    pd_d = pd_q;
    sp_d = sp_q;
    push = 1'b0;
    hold_d = hold_q;
    if (phase_q && state_q == ST_FLUSH) begin
      // The word fetched in a flush cycle is discarded unless it is the
      // target of a long transfer.
      // Transfers keep the counter on their target; skips step past the word.
      state_d = ST_EXEC;
      pc_d = hold_q ? pc_q : pc_next;
    end else if (phase_q) begin
      pc_d = pc_next;
      hold_d = 1'b0;
      case (op)
        OPC_SLEEP: begin
          wdtc_d = 1'b1;
          stop_d = 1'b1;
          to_d = 1'b1;
          pd_d = 1'b0;
        end
        OPC_ENI: ie_d = 1'b1;
        OPC_DISI: ie_d = 1'b0;
        OPC_RETURN, OPC_RETURN_IRQ: begin
          pc_d = top;
          sp_d = sp_q - `ONE3;
          state_d = ST_FLUSH;
          hold_d = 1'b1;
          if (op == OPC_RETURN_IRQ) begin
            ie_d = 1'b1;
          end
        end
        OPC_RETURN_LIT: begin
          acc_d = dec.lit8;
          pc_d = top;
          sp_d = sp_q - `ONE3;
          state_d = ST_FLUSH;
          hold_d = 1'b1;
        end
        OPC_MOVRA: reg_write(acc_q);
        OPC_CLRR: reg_write(`ACC_RST);
        OPC_BC: reg_write(src & ~bit_mask);
        OPC_BS: reg_write(src | bit_mask);
        OPC_DEC_ACC_SKIP, OPC_INC_ACC_SKIP: begin
          acc_d = (op == OPC_DEC_ACC_SKIP) ? dec_val : inc_val;
          if (acc_d == `ACC_RST) begin
            state_d = ST_FLUSH;
          end
        end
        OPC_DEC_REG_SKIP, OPC_INC_REG_SKIP: begin
          reg_write((op == OPC_DEC_REG_SKIP) ? dec_val : inc_val);
          if (((op == OPC_DEC_REG_SKIP) ? dec_val : inc_val) == `ACC_RST) begin
            state_d = ST_FLUSH;
          end
        end
        OPC_ROT_CARRY_ACC: begin
          acc_d = {carry_q, src[7:1]};
          carry_d = src[0];
        end
        OPC_SKIP_BIT_CLR, OPC_SKIP_BIT_SET: begin
          if (bit_val == (op == OPC_SKIP_BIT_SET)) begin
            state_d = ST_FLUSH;
          end
        end
        OPC_CALL, OPC_JUMP: begin
          pc_d = page_jump(pc_q, dec.lit10);
          push = (op == OPC_CALL);
          state_d = ST_FLUSH;
          hold_d = 1'b1;
        end
        OPC_LONG_CALL, OPC_LONG_JUMP: begin
          push = (op == OPC_LONG_CALL);
          state_d = ST_FLUSH;
        end
        default: ;
      endcase
      if (push) begin
        sp_d = sp_q + `ONE3;
      end
    end
  end

  // Long transfers take their target from the word fetched in the flush cycle.
  logic long_pending_q, long_pending_d;
  assign long_pending_d = phase_q ? (state_q == ST_EXEC && (op == OPC_LONG_CALL ||
                                     op == OPC_LONG_JUMP)) : long_pending_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      phase_q <= 1'b0;
      state_q <= ST_EXEC;
      pc_q <= `PC_RST;
      acc_q <= `ACC_RST;
      carry_q <= 1'b0;
      addr_q <= `ACC_RST;
      wdata_q <= `ACC_RST;
      we_q <= 1'b0;
      ie_q <= 1'b0;
      wdtc_q <= 1'b0;
      stop_q <= 1'b0;
      to_q <= 1'b1;
      pd_q <= 1'b1;
      sp_q <= `SP_RST;
      long_pending_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      state_q <= state_d;
      pc_q <= (phase_q && state_q == ST_FLUSH && long_pending_q) ?
              instr_word[`PC_W-1:0] : pc_d;
      acc_q <= acc_d;
      carry_q <= carry_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      we_q <= we_d;
      ie_q <= ie_d;
      wdtc_q <= wdtc_d;
      stop_q <= stop_d;
      to_q <= to_d;
      pd_q <= pd_d;
      sp_q <= sp_d;
      long_pending_q <= long_pending_d;
      hold_q <= hold_d;
    end
  end

  // The stack wraps silently after eight pushes, as a fixed-depth stack does.
  always_ff @(posedge mclk) begin
    if (push) begin
      stack_q[sp_q] <= ret_addr;
    end
  end

  assign fetch_addr = pc_q;
  assign reg_addr = addr_q;
  assign reg_wdata = wdata_q;
  assign reg_we = we_q;
  assign acc = acc_q;
  assign carry = carry_q;
  assign irq_enable = ie_q;
  assign wdt_clear = wdtc_q;
  assign osc_stop = stop_q;
  assign timeout_flag = to_q;
  assign powerdown_flag = pd_q;
  assign exec_phase = phase_q;

  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  logic ex;
  assign ex = phase_q && state_q == ST_EXEC;
  sequence s_flush_then_exec;
    ##2 (state_q == ST_FLUSH && phase_q) ##2 (state_q == ST_EXEC);
  endsequence

  a_phase_alternates: assert property (phase_q |=> !phase_q ##1 phase_q)
    else $error("instruction cycle is not two clocks");
  a_jump_two_cycles: assert property (ex && (op == OPC_JUMP || op == OPC_CALL) |->
      s_flush_then_exec)
    else $error("jump did not take two cycles");
  a_pc_reg_write: assert property (ex && op == OPC_MOVRA && addr_q == `PC_REG_ADDR |=>
      pc_q[7:0] == $past(acc_q) && !reg_we && state_q == ST_FLUSH)
    else $error("program counter write not steered");
  a_sleep_effects: assert property (ex && op == OPC_SLEEP |=>
      wdt_clear && osc_stop && timeout_flag && !powerdown_flag ##1 !wdt_clear)
    else $error("sleep effects wrong");
  a_ret_pops: assert property (ex && op == OPC_RETURN |=>
      pc_q == $past(top) && sp_q == $past(sp_q) - `ONE3 && $stable(ie_q))
    else $error("return did not pop");
  a_return_from_irq_op_enables: assert property (ex && op == OPC_RETURN_IRQ |=>
      ie_q && pc_q == $past(top))
    else $error("return from interrupt did not enable");
  a_dec_acc_skip: assert property (ex && op == OPC_DEC_ACC_SKIP |=> acc_q == $past(dec_val) &&
      $stable(carry_q) && ((acc_q == `ACC_RST) == (state_q == ST_FLUSH)))
    else $error("decrement to accumulator wrong");
  a_djz_write: assert property (ex && op == OPC_DEC_REG_SKIP && addr_q != `PC_REG_ADDR |=>
      reg_we && reg_wdata == $past(dec_val) && $stable(acc_q))
    else $error("decrement register wrong");
  a_rotate_carry: assert property (ex && op == OPC_ROT_CARRY_ACC |=>
      acc_q == {$past(carry_q), $past(src[7:1])} && carry_q == $past(src[0]))
    else $error("rotate through carry wrong");
  a_nop_quiet: assert property (ex && op == OPC_NOP |=> pc_q == $past(pc_next) &&
      $stable(acc_q) && !reg_we && state_q == ST_EXEC)
    else $error("no operation changed state");
endmodule

// ---- testbench/code_store_model.sv ----
/*
  Far-side model of the core: program memory and register file.
  Assumes the bench fills mem and regs while the core is held in reset.
*/
`timescale 1ns/100ps
`include "decode_defs.svh"
module code_store_model (
  input wire logic mclk,
  input wire logic [`PC_W-1:0] fetch_addr,
  output logic [`IW_W-1:0] instr_word,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  output logic [7:0] reg_rdata
);
  logic [`IW_W-1:0] mem [0:4095];
  logic [7:0] regs [0:255];

  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 15'h0000;
    end
    for (int i = 0; i < 256; i++) begin
      regs[i] = 8'h00;
    end
  end

  // Both answer at once, well inside the one clock the core allows.
  assign instr_word = mem[fetch_addr];
  assign reg_rdata = regs[reg_addr];

  // Port and general registers share this one write path.
  always @(posedge mclk) begin
    if (reg_we === 1'b1) begin
      regs[reg_addr] <= reg_wdata;
    end
  end
endmodule

// ---- testbench/instruction_decode_timing_tb.sv ----
/*
  Self-checking bench for the instruction decode and timing block.
  Assumes the code store model answers fetches and register reads at once.
*/
`timescale 1ns/100ps
`include "decode_defs.svh"
module instruction_decode_timing_tb;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic [4:0] slot;
  } note_t;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [`IW_W-1:0] instr_word;
  logic [7:0] reg_rdata;
  logic [`PC_W-1:0] fetch_addr;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_we;
  logic [7:0] acc;
  logic carry;
  logic irq_enable;
  logic wdt_clear;
  logic osc_stop;
  logic timeout_flag;
  logic powerdown_flag;
  logic exec_phase;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int t0 = 0;
  int n_sleep = 0;
  note_t q[$];
  note_t nt;
  // Program as address and word; the word at 0x003 must be skipped.
  logic [26:0] prog [0:17] = '{
    {12'h000, 15'h1610}, {12'h001, 15'h0120}, {12'h002, 15'h1711}, {12'h003, 15'h0121},
    {12'h004, 15'h1812}, {12'h005, 15'h0122}, {12'h006, 15'h4040}, {12'h040, 15'h705a},
    {12'h007, 15'h0123}, {12'h008, 15'h7ac0}, {12'h009, 15'h0080}, {12'h080, 15'h40c0},
    {12'h0c0, 15'h0013}, {12'h081, 15'h0003}, {12'h082, 15'h0001}, {12'h083, 15'h0124},
    {12'h084, 15'h0102}, {12'h05a, 15'h505a}};

  always #20 mclk = ~mclk;

  instruction_decode_timing i_instruction_decode_timing (
    .mclk(mclk), .srst(srst), .instr_word(instr_word), .reg_rdata(reg_rdata),
    .fetch_addr(fetch_addr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .acc(acc), .carry(carry), .irq_enable(irq_enable), .wdt_clear(wdt_clear),
    .osc_stop(osc_stop), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
    .exec_phase(exec_phase));

  code_store_model i_code_store_model (
    .mclk(mclk), .fetch_addr(fetch_addr), .instr_word(instr_word), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata));

  task automatic summarize();
    $display("Checks: %0d, mismatches: %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A hang anywhere lands here; 4 runs need well under 400 clocks.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, cyc, 0);
      summarize();
    end
  end

  // Every write must match the oldest note, in value and in cycle slot.
  always @(posedge mclk) begin
    if (srst === 1'b0 && reg_we === 1'b1) begin
      if (q.size() == 0) begin
        err_total++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, {reg_addr, reg_wdata}, 16'h0000);
      end else begin
        nt = q.pop_front();
        if (nt.slot == 5'h01) begin
          t0 = cyc;
        end
        check(32'({reg_addr, reg_wdata}), 32'({nt.addr, nt.data}));
        check(32'(cyc - t0), 32'(2 * (nt.slot - 1)));
      end
    end
    if (srst === 1'b0 && wdt_clear === 1'b1) begin
      n_sleep++;
      check(32'({osc_stop, timeout_flag, powerdown_flag}), 32'h0000_0006);
      check(32'(cyc - t0), 32'h0000_0020);
    end
  end

  task automatic run_once(input logic [7:0] v, input logic [7:0] r, input int it);
    int k;
    srst <= 1'b1;
    foreach (prog[i]) begin
      i_code_store_model.mem[prog[i][26:15]] = prog[i][14:0];
    end
    i_code_store_model.regs[8'h10] = v;
    i_code_store_model.regs[8'h11] = 8'h01;
    i_code_store_model.regs[8'h12] = r;
    repeat (8) @(posedge mclk);
    check(32'({fetch_addr, acc, carry, irq_enable, timeout_flag, powerdown_flag, exec_phase,
      reg_we}), 32'({12'h000, 8'h00, 6'b001100}));
    q.push_back('{8'h20, v - 8'h01, 5'h01});
    q.push_back('{8'h11, 8'h00, 5'h02});
    q.push_back('{8'h22, {1'b0, r[7:1]}, 5'h05});
    q.push_back('{8'h23, 8'h5a, 5'h0a});
    q.push_back('{8'h24, 8'h5a, 5'h13});
    srst <= 1'b0;
    for (k = 0; k < 200 && q.size() != 0; k++) begin
      @(posedge mclk);
    end
    check(32'(q.size()), 32'h0000_0000);
    repeat (10) @(posedge mclk);
    check(32'({acc, carry, irq_enable, wdt_clear, osc_stop}), 32'({8'h5a, r[0], 3'b100}));
    check(32'({fetch_addr[`PC_W-1:1], 1'b0}), 32'h0000_005a);
    check(32'(n_sleep), 32'(it + 1));
    $display("Test %0d done", it);
  endtask

  // Each run after the first resets the core while it spins in its final jump loop.
  initial begin
    void'($urandom(99218));
    for (int it = 0; it < 4; it++) begin
      run_once(8'($urandom_range(255, 2)), 8'($urandom()), it);
    end
    summarize();
  end
endmodule
